/* rtl/rmc_map.vh */
/*
  Constants of the radio mode and configuration control block.
  Assumes a 50 MHz system clock; included by the design files only.
*/
`ifndef RMC_MAP_VH
`define RMC_MAP_VH

`define RMC_CLK_HZ        50000000
`define RMC_CLK_NS        20
`define RMC_PWRUP_NS      800000
`define RMC_PWRUP_CYC     (`RMC_PWRUP_NS / `RMC_CLK_NS)
`define RMC_SETTLE_NS     8900000
`define RMC_SETTLE_CYC    (`RMC_SETTLE_NS / `RMC_CLK_NS)
`define RMC_XTAL_HZ       11059200
`define RMC_BIT_HZ        76800
`define RMC_OVERSAMPLE    8
`define RMC_NCO_W         24
`define RMC_XTAL_INC      ((64'd11059200 * 64'h1000000) / 64'd50000000)
`define RMC_OVS_INC       ((64'd614400 * 64'h1000000) / 64'd50000000)

`define RMC_CFG_W         14
`define RMC_BAND_HI       13
`define RMC_BAND_LO       12
`define RMC_PWR_HI        11
`define RMC_PWR_LO        10
`define RMC_CHAN_HI       9
`define RMC_CHAN_LO       2
`define RMC_HCLK_HI       1
`define RMC_HCLK_LO       0
`define RMC_CFG_RESET     14'h1000
`define RMC_BAND_868      2'h1
`define RMC_PWR_MIN       2'h0

`define RMC_BASE_868      24'h847980
`define RMC_STEP_868      24'h000600
`define RMC_DEV_HZ        16'h59D8

`define RMC_ADDR_CFG      8'h00
`define RMC_ADDR_STATUS   8'h04
`define RMC_ADDR_CTRL     8'h08
`define RMC_CTRL_RESET    32'h00000001
`define RMC_SYNC_RESET    7'h02

`endif

/* rtl/rmc_rate_nco.v */
/*
  Phase accumulator giving a one-cycle tick on each wrap and a square wave.
  Assumes the increment is stable while enabled; runs on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rmc_rate_nco #(
  parameter W = 24
) (
  input  wire         clk_in,
  input  wire         reset_n_in,
  input  wire         enable_in,
  input  wire [W-1:0] inc_in,
  output reg          tick_out,
  output wire         wave_out
);
  reg  [W-1:0] acc;
  wire [W:0]   next_acc;

  assign next_acc = {1'b0, acc} + {1'b0, inc_in};
  assign wave_out = acc[W-1];

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      acc      <= {W{1'b0}};
      tick_out <= 1'b0;
    end else if (enable_in) begin
      acc      <= next_acc[W-1:0];
      tick_out <= next_acc[W];
    end else begin
      acc      <= {W{1'b0}};
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* rtl/rmc_gauss_fir.v */
/*
  Gaussian-shaped smoothing of oversampled transmit bits.
  Taps 1,1,2,4,4,2,1,1 sum to 16, so the level spans -16 to +16.
  Assumes shift_in is high for one cycle per oversample period.
*/
`timescale 1ns/1ps
`default_nettype none
module rmc_gauss_fir #(
  parameter TAPS = 8
) (
  input  wire              clk_in,
  input  wire              reset_n_in,
  input  wire              shift_in,
  input  wire              bit_in,
  output reg  signed [5:0] level_out
);
  localparam [4*TAPS-1:0] WEIGHTS = 32'h11244211;

  reg        [TAPS-1:0] hist;
  reg signed [5:0]      next_level;
  reg        [4:0]      w;
  integer               i;

  always @* begin
    next_level = 6'sh00;
    w          = 5'h00;
    for (i = 0; i < TAPS; i = i + 1) begin
      w = {1'b0, WEIGHTS[4*i +: 4]};
      if (hist[i])
        next_level = next_level + $signed({1'b0, w});
      else
        next_level = next_level - $signed({1'b0, w});
    end
  end

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      hist      <= {TAPS{1'b0}};
      level_out <= 6'sh00;
    end else if (shift_in) begin
      hist      <= {hist[TAPS-2:0], bit_in};
      level_out <= next_level;
    end
  end
endmodule
`default_nettype wire

/* rtl/rmc_top.v */
/*
  Digital control face of the transceiver: mode pins, configuration word
  loaded serially or over AHB-Lite, shared data pin, host clock output and
  the Gaussian FSK frequency offset fed to the synthesiser.
  Assumes pins are asynchronous to clk_in; the receive chain supplies
  demodulated bits on clk_in; one AHB-Lite master drives the slave port.
*/
// Register access over AHB-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rmc_map.vh"
module rmc_top #(
  parameter PWRUP_CYC  = `RMC_PWRUP_CYC,
  parameter SETTLE_CYC = `RMC_SETTLE_CYC
) (
  input  wire        clk_in,
  input  wire        reset_n_in,
  // AHB-Lite slave
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output wire [31:0] hrdata_out,
  output wire        hreadyout_out,
  output wire        hresp_out,
  // Mode pins
  input  wire        low_activity_select_in,
  input  wire        sleep_select_in,
  input  wire        transmit_select_in,
  // Serial configuration pins
  input  wire        cfg_select_in,
  input  wire        cfg_sck_in,
  input  wire        cfg_sdi_in,
  // Shared data pin
  input  wire        data_in,
  output reg         data_out,
  output wire        data_oe_n_out,
  // Host clock pin
  output reg         host_clk_out,
  // Receive chain and synthesiser side
  input  wire        demod_bit_in,
  output reg  [23:0] centre_freq_out,
  output reg  signed [15:0] freq_offset_out,
  output reg  [1:0]  pa_level_out,
  output reg         rx_enable_out,
  output reg         tx_enable_out,
  output reg         synth_retune_out
);
  localparam [3:0] MODE_SLEEP   = 4'h1;
  localparam [3:0] MODE_STANDBY = 4'h2;
  localparam [3:0] MODE_RX      = 4'h4;
  localparam [3:0] MODE_TX      = 4'h8;
  localparam       NW           = `RMC_NCO_W;
  localparam [63:0]   XTAL_INC_W = `RMC_XTAL_INC;
  localparam [63:0]   OVS_INC_W  = `RMC_OVS_INC;
  localparam [NW-1:0] XTAL_INC   = XTAL_INC_W[NW-1:0];
  localparam [NW-1:0] OVS_INC    = OVS_INC_W[NW-1:0];

  // Pin synchronisers: stage one feeds only stage two
  reg  [6:0] sync_a;
  reg  [6:0] sync_b;
  wire       low_act_s  = sync_b[0];
  wire       sleep_s    = sync_b[1];
  wire       txsel_s    = sync_b[2];
  wire       data_s     = sync_b[3];
  wire       cs_s       = sync_b[4];
  wire       sck_s      = sync_b[5];
  wire       sdi_s      = sync_b[6];

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      // Reset as if sleep were selected: no false receive mode before pins arrive
      sync_a <= `RMC_SYNC_RESET;
      sync_b <= `RMC_SYNC_RESET;
    end else begin
      sync_a <= {cfg_sdi_in, cfg_sck_in, cfg_select_in, data_in,
                 transmit_select_in, sleep_select_in, low_activity_select_in};
      sync_b <= sync_a;
    end
  end

  // Mode decode
  reg [3:0] mode;
  reg [3:0] next_mode;

  always @* begin
    if (sleep_s)
      next_mode = MODE_SLEEP;
    else if (low_act_s)
      next_mode = MODE_STANDBY;
    else if (txsel_s)
      next_mode = MODE_TX;
    else
      next_mode = MODE_RX;
  end

  always @(posedge clk_in) begin
    if (!reset_n_in)
      mode <= MODE_SLEEP;
    else
      mode <= next_mode;
  end

  // Configuration word, serial path
  reg [`RMC_CFG_W-1:0] cfg;
  reg [`RMC_CFG_W-1:0] shift;
  reg                  cs_d;
  reg                  sck_d;
  reg [31:0]           ctrl;
  wire                 serial_en   = ctrl[0];
  wire                 cs_fall     = cs_d & ~cs_s & serial_en;
  wire                 sck_rise    = sck_s & ~sck_d;

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      cs_d  <= 1'b0;
      sck_d <= 1'b0;
      shift <= `RMC_CFG_RESET;
    end else begin
      cs_d  <= cs_s;
      sck_d <= sck_s;
      if (cs_s && sck_rise && serial_en)
        shift <= {shift[`RMC_CFG_W-2:0], sdi_s};
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  reg        ph_write;
  reg        ph_read;
  reg [7:0]  ph_addr;
  reg [31:0] rdata;
  wire       ahb_go  = hsel_in & htrans_in[1] & hready_in;
  wire       wr_cfg  = ph_write & (ph_addr == `RMC_ADDR_CFG);
  wire       wr_ctrl = ph_write & (ph_addr == `RMC_ADDR_CTRL);

  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = rdata;

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      ph_write <= 1'b0;
      ph_read  <= 1'b0;
      ph_addr  <= 8'h00;
    end else begin
      ph_write <= ahb_go & hwrite_in;
      ph_read  <= ahb_go & ~hwrite_in;
      ph_addr  <= {haddr_in[7:2], 2'h0};
    end
  end

  // Timers: start-up of the host clock, synthesiser settling
  reg  [31:0] pwrup_cnt;
  reg         clk_ready;
  reg  [31:0] settle_cnt;
  reg         settled;
  wire        retune = cs_fall | wr_cfg;

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      cfg              <= `RMC_CFG_RESET;
      ctrl             <= `RMC_CTRL_RESET;
      synth_retune_out <= 1'b0;
    end else begin
      synth_retune_out <= retune;
      if (wr_cfg)
        cfg <= hwdata_in[`RMC_CFG_W-1:0];
      else if (cs_fall)
        cfg <= shift;
      if (wr_ctrl)
        ctrl <= {31'h00000000, hwdata_in[0]};
    end
  end

  // Host clock appears once the oscillator has run its start-up time
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      pwrup_cnt <= 32'h00000000;
      clk_ready <= 1'b0;
    end else if (!clk_ready) begin
      if (pwrup_cnt >= PWRUP_CYC - 1)
        clk_ready <= 1'b1;
      else
        pwrup_cnt <= pwrup_cnt + 32'h00000001;
    end
  end

  // Restarts on each retune; receive data is muted until it expires
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      settle_cnt <= 32'h00000000;
      settled    <= 1'b0;
    end else if (retune) begin
      settle_cnt <= 32'h00000000;
      settled    <= 1'b0;
    end else if (!settled) begin
      if (settle_cnt >= SETTLE_CYC - 1)
        settled <= 1'b1;
      else
        settle_cnt <= settle_cnt + 32'h00000001;
    end
  end

  // Host clock: crystal rate shifted down by the select field
  wire [1:0]    hclk_sel = cfg[`RMC_HCLK_HI:`RMC_HCLK_LO];
  wire [NW-1:0] hclk_inc = XTAL_INC >> hclk_sel;
  wire          hclk_wave;
  wire          hclk_run = clk_ready & (mode != MODE_SLEEP);

  rmc_rate_nco #(
    .W (NW)
  ) u_host_nco (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .enable_in  (hclk_run),
    .inc_in     (hclk_inc),
    .tick_out   (),
    .wave_out   (hclk_wave)
  );

  always @(posedge clk_in) begin
    if (!reset_n_in)
      host_clk_out <= 1'b0;
    else
      host_clk_out <= hclk_run & hclk_wave;
  end

  // Transmit bit path: oversampled at eight times the bit rate
  wire              ovs_tick;
  wire signed [5:0] level;
  wire              tx_on = (mode == MODE_TX);

  rmc_rate_nco #(
    .W (NW)
  ) u_ovs_nco (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .enable_in  (tx_on),
    .inc_in     (OVS_INC),
    .tick_out   (ovs_tick),
    .wave_out   ()
  );

  rmc_gauss_fir #(
    .TAPS (`RMC_OVERSAMPLE)
  ) u_fir (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .shift_in   (ovs_tick),
    .bit_in     (data_s),
    .level_out  (level)
  );

  // Level of +16 means full deviation above centre, -16 below
  wire signed [22:0] dev_prod = level * $signed({1'b0, `RMC_DEV_HZ});
  wire [1:0]         band     = cfg[`RMC_BAND_HI:`RMC_BAND_LO];
  wire [7:0]         channel  = cfg[`RMC_CHAN_HI:`RMC_CHAN_LO];
  wire               band_ok  = (band == `RMC_BAND_868);
  wire [23:0]        chan_step = channel * `RMC_STEP_868;

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      freq_offset_out <= 16'sh0000;
      centre_freq_out <= 24'h000000;
      pa_level_out    <= `RMC_PWR_MIN;
      rx_enable_out   <= 1'b0;
      tx_enable_out   <= 1'b0;
    end else begin
      freq_offset_out <= tx_on ? dev_prod[19:4] : 16'sh0000;
      centre_freq_out <= band_ok ? (`RMC_BASE_868 + chan_step) : 24'h000000;
      pa_level_out    <= cfg[`RMC_PWR_HI:`RMC_PWR_LO];
      rx_enable_out   <= (mode == MODE_RX);
      tx_enable_out   <= tx_on;
    end
  end

  // Data pin: driven only in receive mode, muted until the synthesiser settles
  assign data_oe_n_out = ~(mode == MODE_RX);

  always @(posedge clk_in) begin
    if (!reset_n_in)
      data_out <= 1'b0;
    else
      data_out <= (mode == MODE_RX) & settled & demod_bit_in;
  end

  // Register read mux; status shows mode, readiness and band validity
  always @(posedge clk_in) begin
    if (!reset_n_in)
      rdata <= 32'h00000000;
    else if (ahb_go && !hwrite_in) begin
      case ({haddr_in[7:2], 2'h0})
        `RMC_ADDR_CFG:    rdata <= {18'h00000, cfg};
        `RMC_ADDR_STATUS: rdata <= {25'h0000000, band_ok, settled, clk_ready, mode};
        `RMC_ADDR_CTRL:   rdata <= ctrl;
        default:          rdata <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

/* test/rmc_top_sva.sv */
/*
  Port checker for rmc_top: mode levels, pin direction, offsets, retune, start-up.
  Assumes binding into rmc_top, with PWRUP_CYC handed on by the bind.
*/
`timescale 1ns/1ps
`default_nettype none
module rmc_top_chk #(
  parameter PWRUP_CYC = 40000
) (
  input wire logic               clk_in,
  input wire logic               reset_n_in,
  input wire logic               low_activity_select_in,
  input wire logic               sleep_select_in,
  input wire logic               transmit_select_in,
  input wire logic               data_oe_n_out,
  input wire logic               host_clk_out,
  input wire logic [23:0]        centre_freq_out,
  input wire logic signed [15:0] freq_offset_out,
  input wire logic               rx_enable_out,
  input wire logic               tx_enable_out,
  input wire logic               synth_retune_out
);
  logic [31:0] up_cnt;

  // Counts from reset release; saturates so it costs nothing afterwards
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) up_cnt <= 32'h0;
    else if (up_cnt < PWRUP_CYC) up_cnt <= up_cnt + 32'h1;
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_rx;
    !sleep_select_in && !low_activity_select_in && !transmit_select_in;
  endsequence
  sequence s_tx;
    !sleep_select_in && !low_activity_select_in && transmit_select_in;
  endsequence

  property p_rx_mode;
    s_rx [*5] |-> rx_enable_out && !tx_enable_out && !data_oe_n_out;
  endproperty
  a_rx_mode: assert property (p_rx_mode) else $error("receive mode not taken");
  property p_tx_mode;
    s_tx [*5] |-> tx_enable_out && !rx_enable_out && data_oe_n_out;
  endproperty
  a_tx_mode: assert property (p_tx_mode) else $error("transmit mode not taken");
  property p_sleep;
    sleep_select_in [*5] |-> !rx_enable_out && !tx_enable_out && data_oe_n_out;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not honoured");
  property p_tx_quiet;
    !tx_enable_out [*3] |-> freq_offset_out == 16'sh0;
  endproperty
  a_tx_quiet: assert property (p_tx_quiet) else $error("offset outside transmit");
  property p_dev;
    freq_offset_out <= 16'sh59D8 && freq_offset_out >= -16'sh59D8;
  endproperty
  a_dev: assert property (p_dev) else $error("offset beyond deviation");
  property p_centre;
    centre_freq_out != 24'h0 |-> centre_freq_out >= 24'h847980
      && (centre_freq_out - 24'h847980) % 24'h000600 == 24'h0;
  endproperty
  a_centre: assert property (p_centre) else $error("centre off channel grid");
  property p_retune;
    $rose(synth_retune_out) |=> !synth_retune_out;
  endproperty
  a_retune: assert property (p_retune) else $error("retune strobe too long");
  property p_hclk_up;
    up_cnt < PWRUP_CYC - 1 |-> !host_clk_out;
  endproperty
  a_hclk_up: assert property (p_hclk_up) else $error("host clock too early");

  c_tx: cover property (tx_enable_out && freq_offset_out > 16'sh0);
  c_rx: cover property (rx_enable_out && centre_freq_out != 24'h0);
  c_retune: cover property (synth_retune_out);
endmodule
bind rmc_top rmc_top_chk #(.PWRUP_CYC(PWRUP_CYC)) u_chk (.*);
`default_nettype wire

/* test/rmc_host_model.sv */
/*
  Host controller model: mode pins, serial configuration load, transmit bits.
  Assumes the bench calls its tasks; every pin changes just after clk_in rises.
*/
`timescale 1ns/1ps
`default_nettype none
module rmc_host_model (
  input  wire logic clk_in,
  output var logic  low_activity_select_out,
  output var logic  sleep_select_out,
  output var logic  transmit_select_out,
  output var logic  cfg_select_out,
  output var logic  cfg_sck_out,
  output var logic  cfg_sdi_out,
  output var logic  tx_bit_out
);
  localparam int BIT_CYC = 651;

  initial begin
    low_activity_select_out = 1'b1;
    sleep_select_out = 1'b0;
    transmit_select_out = 1'b0;
    cfg_select_out = 1'b0;
    cfg_sck_out = 1'b0;
    cfg_sdi_out = 1'b0;
    tx_bit_out = 1'b0;
  end

  task automatic set_mode(input logic sl, input logic la, input logic tx);
    @(posedge clk_in);
    sleep_select_out <= sl;
    low_activity_select_out <= la;
    transmit_select_out <= tx;
  endtask

  // Clock phases of 4 cycles keep clear of the 3-cycle synchroniser minimum
  task automatic load_word(input logic [13:0] w);
    set_mode(1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge clk_in);
    cfg_select_out <= 1'b1;
    for (int i = 13; i >= 0; i--) begin
      cfg_sdi_out <= w[i];
      repeat (4) @(posedge clk_in);
      cfg_sck_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      cfg_sck_out <= 1'b0;
    end
    repeat (4) @(posedge clk_in);
    cfg_select_out <= 1'b0;
    cfg_sdi_out <= ~w[0];
  endtask

  task automatic send_bit(input logic b);
    @(posedge clk_in);
    tx_bit_out <= b;
    repeat (BIT_CYC - 1) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

/* test/radio_mode_config_control_tb.sv */
/*
  Self-checking bench for rmc_top: AHB-Lite register access and a host model.
  Assumes the design, the checker and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module radio_mode_config_control_tb;
  localparam int PW = 20;
  localparam int ST = 50;
  logic        clk_in;
  logic        reset_n_in;
  logic        hsel, hwrite, hready, hresp, demod, hc_q;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, pa;
  logic [2:0]  hsize;
  logic        la, sl, txs, cs, sck, sdi, hbit, d_out, oe_n, hclk, rxe, txe, retune;
  logic [23:0] centre;
  logic [15:0] off;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          n;
  wire         data_pin = oe_n ? hbit : d_out;

  rmc_top #(.PWRUP_CYC(PW), .SETTLE_CYC(ST)) u_dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .low_activity_select_in(la), .sleep_select_in(sl), .transmit_select_in(txs),
    .cfg_select_in(cs), .cfg_sck_in(sck), .cfg_sdi_in(sdi), .data_in(data_pin),
    .data_out(d_out), .data_oe_n_out(oe_n), .host_clk_out(hclk), .demod_bit_in(demod),
    .centre_freq_out(centre), .freq_offset_out(off), .pa_level_out(pa),
    .rx_enable_out(rxe), .tx_enable_out(txe), .synth_retune_out(retune));

  rmc_host_model u_host (
    .clk_in(clk_in), .low_activity_select_out(la), .sleep_select_out(sl),
    .transmit_select_out(txs), .cfg_select_out(cs), .cfg_sck_out(sck),
    .cfg_sdi_out(sdi), .tx_bit_out(hbit));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask

  // Sampled in the active region, so this sees the values the slave presented
  task automatic wait_ready(inout int t);
    do begin
      @(posedge clk_in);
      t++;
    end while (hready !== 1'b1 && t < 50);
    if (t >= 50) begin
      n_mismatch++;
      summarize();
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rv);
    int t;
    t = 0;
    @(posedge clk_in);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready(t);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(t);
    rv = hrdata;
  endtask

  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    chk(nm, v & m, e);
  endtask

  initial begin
    reset_n_in = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hsize = 3'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    demod = 1'b0;
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    for (n = 0; n < 200 && hclk !== 1'b1; n++) tick();
    chk("clock_start", 32'(n >= PW && n <= PW + 12), 32'h1);
    rdc("cfg_reset", 32'h0, 32'hFFFFFFFF, 32'h00001000);
    rdc("ctrl_reset", 32'h8, 32'hFFFFFFFF, 32'h00000001);
    rdc("standby", 32'h4, 32'h0000001F, 32'h00000012);
    ahb(1'b1, 32'h0000000C, 32'hFFFFFFFF, rd);
    rdc("unmapped", 32'hC, 32'hFFFFFFFF, 32'h0);
    chk("resp_okay", {30'h0, hresp, hready}, 32'h1);
    // Band 868, minimum power, channel 5, half-rate host clock
    u_host.load_word(14'h1015);
    for (n = 0; n < 20 && retune !== 1'b1; n++) tick();
    chk("retune_delay", 32'(n >= 1 && n <= 6), 32'h1);
    rdc("cfg_serial", 32'h0, 32'hFFFFFFFF, 32'h00001015);
    chk("centre_ch5", {8'h0, centre}, 32'h00849780);
    chk("power_min", {30'h0, pa}, 32'h0);
    rdc("rx_status", 32'h4, 32'h0000004F, 32'h00000044);
    repeat (ST + 10) @(posedge clk_in);
    for (int b = 1; b >= 0; b--) begin
      @(posedge clk_in);
      demod <= 1'(b);
      tick();
      tick();
      chk("rx_data", {31'h0, data_pin}, 32'(b));
    end
    rd = 32'h0;
    hc_q = hclk;
    for (n = 0; n < 904; n++) begin
      tick();
      if (hclk === 1'b1 && hc_q === 1'b0) rd = rd + 32'h1;
      hc_q = hclk;
    end
    chk("host_clk_rate", 32'(rd >= 32'h62 && rd <= 32'h65), 32'h1);
    ahb(1'b1, 32'h0, 32'h00001C04, rd);
    repeat (4) tick();
    chk("centre_ch1", {8'h0, centre}, 32'h00847F80);
    chk("power_field", {30'h0, pa}, 32'h3);
    u_host.set_mode(1'b0, 1'b0, 1'b1);
    repeat (5) tick();
    chk("tx_mode", {29'h0, txe, oe_n, rxe}, 32'h6);
    u_host.send_bit(1'b1);
    u_host.send_bit(1'b1);
    #1;
    chk("dev_one", {16'h0, off}, 32'h000059D8);
    u_host.send_bit(1'b0);
    u_host.send_bit(1'b0);
    #1;
    chk("dev_zero", {16'h0, off}, 32'h0000A628);
    u_host.set_mode(1'b1, 1'b0, 1'b0);
    repeat (5) tick();
    rdc("sleep_status", 32'h4, 32'h0000000F, 32'h00000001);
    summarize();
  end
endmodule
`default_nettype wire
